/* File: mpm_mailbox.sv */
module mpm_mailbox
   import mpm_pkg::*;
(
   input  wire logic        CORE_CLK,   // Core clock, 10 MHz.
   input  wire logic        RESETN,     // Asynchronous reset, active low.
   input  wire logic        CLK_EN,     // Freezes all state while low.
   input  wire logic [15:0] REG_ADDR,   // Holding register address from the Modbus stack.
   input  wire logic        REG_WR,     // Write strobe for one register.
   input  wire logic [15:0] REG_WDATA,  // Register write data.
   input  wire logic        REG_RD,     // Read strobe for one register.
   output logic      [15:0] REG_RDATA,  // Read data, valid the cycle after REG_RD.
   output logic             REG_HIT,    // Address falls in the mailbox window.
   output logic             JOB_START,  // One-cycle pulse launching the parameter engine.
   output mpm_job_t         JOB,        // Job fields, stable from JOB_START to JOB_DONE.
   input  wire logic        JOB_DONE,   // Engine finished, one-cycle pulse.
   input  mpm_result_t      JOB_RESULT  // Engine outcome, valid with JOB_DONE.
);
   mpm_state_t  state_q, state_d;
   logic [15:0] mbx_q [MBX_WORDS];
   logic [15:0] mbx_d [MBX_WORDS];
   logic [15:0] rdata_q, rdata_d;
   logic        start_q, start_d;
   mpm_job_t    job_q, job_d;
   logic [15:0] offset;
   logic [3:0]  idx;
   logic        in_window;
   logic [7:0]  req_len;
   logic        idle;
   logic        wr_hit;
   logic        ctrl_wr;
   logic        launch_wr;
   logic [7:0]  launch_fault;
   logic [7:0]  engine_fault;
   logic [7:0]  read_len;

   assign offset    = REG_ADDR - MBX_BASE;
   assign in_window = (REG_ADDR >= MBX_BASE) && (offset < 16'(MBX_WORDS));
   assign idx       = offset[3:0];
   assign REG_HIT   = in_window;
   assign REG_RDATA = rdata_q;
   assign JOB_START = start_q;
   assign JOB       = job_q;
   assign req_len   = mbx_q[IDX_FUNC_LEN][7:0];
   assign idle      = (state_q == ST_FILL) || (state_q == ST_DONE);
   assign wr_hit    = REG_WR && in_window;
   assign ctrl_wr   = wr_hit && (idx == IDX_CONTROL);
   assign launch_wr = ctrl_wr && (REG_WDATA == CTRL_ACTIVE);

   // Launch checks in order of precedence; a job that fails them never reaches the engine.
   always_comb begin
      if (mbx_q[IDX_FUNC_LEN][15:8] != FUNC_PARAM) begin
         launch_fault = FAULT_FUNCTION;
      end else if (req_len < LEN_REQ_MIN || req_len > LEN_REQ_MAX) begin
         launch_fault = FAULT_LENGTH;
      end else if (mbx_q[IDX_REF_TYPE][7:0] != TYPE_READ && mbx_q[IDX_REF_TYPE][7:0] != TYPE_CHANGE) begin
         launch_fault = FAULT_STATE;
      end else begin
         launch_fault = FAULT_NONE;
      end
   end

   // An engine that fails without naming a cause is reported as an internal error.
   assign engine_fault = (JOB_RESULT.fault == FAULT_NONE) ? FAULT_INTERNAL : JOB_RESULT.fault;
   assign read_len     = JOB_RESULT.wide ? LEN_READ_BASE + LEN_VALUE_WIDE
                                         : LEN_READ_BASE + LEN_VALUE_NARROW;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_FILL, ST_DONE: begin
            if (ctrl_wr && REG_WDATA == CTRL_FILLING) begin
               state_d = ST_FILL;
            end else if (launch_wr) begin
               state_d = (launch_fault == FAULT_NONE) ? ST_BUSY : ST_FINISH;
            end
         end
         ST_BUSY: begin
            if (JOB_DONE) begin
               // The payload is rewritten here and the control word moves on one cycle later.
               state_d = ST_FINISH;
            end
         end
         ST_FINISH: begin
            state_d = ST_DONE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= ST_FILL;
      end else if (CLK_EN) begin
         state_q <= state_d;
      end
   end

   always_comb begin
      start_d = 1'b0;
      job_d   = job_q;
      if (idle && launch_wr && launch_fault == FAULT_NONE) begin
         start_d                  = 1'b1;
         job_d.reference          = mbx_q[IDX_REF_TYPE][15:8];
         job_d.job_type           = mbx_q[IDX_REF_TYPE][7:0];
         job_d.drive_object_index = mbx_q[IDX_OBJ_COUNT][15:8];
         job_d.param_count        = mbx_q[IDX_OBJ_COUNT][7:0];
         job_d.attribute          = mbx_q[IDX_ATTR_ELEM][15:8];
         job_d.elements           = mbx_q[IDX_ATTR_ELEM][7:0];
         job_d.param_number       = mbx_q[IDX_PARAM_NUM];
         job_d.subindex           = mbx_q[IDX_SUBINDEX];
         job_d.value_format       = mbx_q[IDX_VALUE_FMT];
         job_d.value              = {mbx_q[IDX_VALUE_HIGH], mbx_q[IDX_VALUE_LOW]};
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         start_q <= 1'b0;
         job_q   <= '0;
      end else if (CLK_EN) begin
         start_q <= start_d;
         job_q   <= job_d;
      end
   end

   always_comb begin
      mbx_d = mbx_q;
      if (idle && wr_hit && idx != IDX_CONTROL) begin
         // Payload writes are taken only outside a running job, so the engine sees a frozen request.
         mbx_d[idx] = REG_WDATA;
      end else if (idle && launch_wr && launch_fault != FAULT_NONE) begin
         mbx_d[IDX_FUNC_LEN] = {FUNC_PARAM, LEN_ERROR};
         mbx_d[IDX_REF_TYPE] = {8'h00, launch_fault};
      end else if (state_q == ST_BUSY && JOB_DONE) begin
         if (JOB_RESULT.ok) begin
            mbx_d[IDX_REF_TYPE] = {job_q.reference, job_q.job_type};
            if (job_q.job_type == TYPE_READ) begin
               mbx_d[IDX_FUNC_LEN]  = {FUNC_PARAM, read_len};
               mbx_d[IDX_ATTR_ELEM] = {JOB_RESULT.format, job_q.elements};
               if (JOB_RESULT.wide) begin
                  mbx_d[IDX_PARAM_NUM] = JOB_RESULT.value[31:16];
                  mbx_d[IDX_SUBINDEX]  = JOB_RESULT.value[15:0];
               end else begin
                  mbx_d[IDX_PARAM_NUM] = JOB_RESULT.value[15:0];
               end
            end else begin
               mbx_d[IDX_FUNC_LEN] = {FUNC_PARAM, LEN_CHANGE_RESP};
            end
         end else begin
            mbx_d[IDX_FUNC_LEN] = {FUNC_PARAM, LEN_ERROR};
            mbx_d[IDX_REF_TYPE] = {8'h00, engine_fault};
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         for (int i = 0; i < MBX_WORDS; i++) begin
            mbx_q[i] <= '0;
         end
      end else if (CLK_EN) begin
         mbx_q <= mbx_d;
      end
   end

   // A read sees the state before any write of the same cycle, so a launch never answers itself.
   always_comb begin
      rdata_d = rdata_q;
      if (REG_RD) begin
         rdata_d = '0;
         if (in_window) begin
            unique case (state_q)
               ST_FILL: rdata_d = (idx == IDX_CONTROL) ? CTRL_FILLING : mbx_q[idx];
               ST_DONE: rdata_d = (idx == IDX_CONTROL) ? CTRL_DONE : mbx_q[idx];
               ST_BUSY, ST_FINISH: begin
                  // Busy answers never expose a half-written payload.
                  if (idx == IDX_CONTROL) begin
                     rdata_d = CTRL_ACTIVE;
                  end else if (idx == IDX_FUNC_LEN) begin
                     rdata_d = {FUNC_PARAM, LEN_ERROR};
                  end else if (idx == IDX_REF_TYPE) begin
                     rdata_d = {8'h00, FAULT_NOT_READY};
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_q <= '0;
      end else if (CLK_EN) begin
         rdata_q <= rdata_d;
      end
   end
endmodule : mpm_mailbox

/* File: mpm_pkg.sv */
package mpm_pkg;
   localparam logic [15:0] MBX_BASE        = 16'h0258;
   localparam int          MBX_WORDS       = 16;
   localparam logic [3:0]  IDX_CONTROL     = 4'h0;
   localparam logic [3:0]  IDX_FUNC_LEN    = 4'h1;
   localparam logic [3:0]  IDX_REF_TYPE    = 4'h2;
   localparam logic [3:0]  IDX_OBJ_COUNT   = 4'h3;
   localparam logic [3:0]  IDX_ATTR_ELEM   = 4'h4;
   localparam logic [3:0]  IDX_PARAM_NUM   = 4'h5;
   localparam logic [3:0]  IDX_SUBINDEX    = 4'h6;
   localparam logic [3:0]  IDX_VALUE_FMT   = 4'h7;
   localparam logic [3:0]  IDX_VALUE_HIGH  = 4'h8;
   localparam logic [3:0]  IDX_VALUE_LOW   = 4'h9;
   localparam logic [3:0]  IDX_LAST        = 4'hf;
   localparam logic [15:0] CTRL_FILLING    = 16'h0000;
   localparam logic [15:0] CTRL_ACTIVE     = 16'h0001;
   localparam logic [15:0] CTRL_DONE       = 16'h0002;
   localparam logic [7:0]  FUNC_PARAM      = 8'h2f;
   localparam logic [7:0]  TYPE_READ       = 8'h01;
   localparam logic [7:0]  TYPE_CHANGE     = 8'h02;
   localparam logic [7:0]  LEN_CHANGE_RESP = 8'h04;
   localparam logic [7:0]  LEN_READ_BASE   = 8'h06;
   localparam logic [7:0]  LEN_REQ_MIN     = 8'h0a;
   localparam logic [7:0]  LEN_REQ_MAX     = 8'h1e;
   localparam logic [7:0]  LEN_ERROR       = 8'h00;
   localparam logic [7:0]  FAULT_LENGTH    = 8'h01;
   localparam logic [7:0]  FAULT_STATE     = 8'h02;
   localparam logic [7:0]  FAULT_FUNCTION  = 8'h03;
   localparam logic [7:0]  FAULT_NOT_READY = 8'h04;
   localparam logic [7:0]  FAULT_INTERNAL  = 8'h05;
   localparam logic [7:0]  FAULT_NONE      = 8'h00;
   localparam logic [7:0]  LEN_VALUE_NARROW = 8'h02;
   localparam logic [7:0]  LEN_VALUE_WIDE   = 8'h04;

   typedef enum logic [3:0] {
      ST_FILL   = 4'b0001,
      ST_BUSY   = 4'b0010,
      ST_FINISH = 4'b0100,
      ST_DONE   = 4'b1000
   } mpm_state_t;

   typedef struct packed {
      logic [7:0]  reference;
      logic [7:0]  job_type;
      logic [7:0]  drive_object_index;
      logic [7:0]  param_count;
      logic [7:0]  attribute;
      logic [7:0]  elements;
      logic [15:0] param_number;
      logic [15:0] subindex;
      logic [15:0] value_format;
      logic [31:0] value;
   } mpm_job_t;

   typedef struct packed {
      logic        ok;
      logic [7:0]  fault;
      logic [7:0]  format;
      logic        wide;
      logic [31:0] value;
   } mpm_result_t;
endpackage : mpm_pkg

/* File: mpm_monitor.sv */
module mpm_monitor
   import mpm_pkg::*;
(
   input wire logic        CORE_CLK,   // Clock.
   input wire logic        RESETN,     // Reset.
   input wire logic        CLK_EN,     // Enable.
   input wire logic [15:0] REG_ADDR,   // Address.
   input wire logic        REG_WR,     // Write.
   input wire logic [15:0] REG_WDATA,  // Data in.
   input wire logic        REG_RD,     // Read.
   input wire logic [15:0] REG_RDATA,  // Data out.
   input wire logic        REG_HIT,    // Hit.
   input wire logic        JOB_START,  // Launch.
   input wire mpm_job_t    JOB         // Job.
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   launch_cause_a: assert property (JOB_START |-> $past(CLK_EN && REG_WR && REG_ADDR == MBX_BASE && REG_WDATA == CTRL_ACTIVE))
      else $error("launch without control write");
   launch_pulse_a: assert property (JOB_START |=> !JOB_START)
      else $error("launch longer than one cycle");
   launch_type_a: assert property (JOB_START |-> JOB.job_type == TYPE_READ || JOB.job_type == TYPE_CHANGE)
      else $error("launch with bad job type");
   window_hit_a: assert property (REG_HIT == (REG_ADDR >= MBX_BASE && REG_ADDR <= MBX_BASE + 16'h000f))
      else $error("window decode wrong");
   outside_zero_a: assert property (CLK_EN && REG_RD && !REG_HIT |=> REG_RDATA == 16'h0000)
      else $error("outside read not zero");
   rdata_hold_a: assert property (!(CLK_EN && REG_RD) |=> $stable(REG_RDATA))
      else $error("read data moved");
   busy_ctrl_a: assert property (JOB_START && CLK_EN && REG_RD && REG_ADDR == MBX_BASE |=> REG_RDATA == CTRL_ACTIVE)
      else $error("busy control not 1");
   busy_code_a: assert property (JOB_START && CLK_EN && REG_RD && REG_ADDR == MBX_BASE + 16'h0002
      |=> REG_RDATA == {8'h00, FAULT_NOT_READY}) else $error("busy code not 4");
endmodule : mpm_monitor
bind mpm_mailbox mpm_monitor mon (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR),
   .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT),
   .JOB_START(JOB_START), .JOB(JOB));

/* File: mpm_engine_model.sv */
module mpm_engine_model
   import mpm_pkg::*;
(
   input  wire logic        core_clk,  // Clock.
   input  wire logic        start,     // Launch pulse.
   input  wire logic [7:0]  delay,     // Extra wait.
   input  wire mpm_result_t outcome,   // Result to give.
   output logic             done,      // Done pulse.
   output mpm_result_t      result     // Valid with done.
);
   timeunit 1ns;
   timeprecision 1ns;
   // Outside the done cycle the result is scrambled, so early sampling shows up.
   assign result = done ? outcome : ~outcome;
   initial done = 1'b0;
   always @(posedge core_clk) if (start) begin
      repeat (delay) @(posedge core_clk);
      done <= 1'b1;
      @(posedge core_clk);
      done <= 1'b0;
   end
endmodule : mpm_engine_model

/* File: mpm_mailbox_bench.sv */
module mpm_mailbox_bench
   import mpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go, reg_hit, job_start, job_done;
   logic        clk_en = 1'b1;
   logic [7:0]  delay = 8'h00, ref_b, f;
   logic [15:0] reg_addr = MBX_BASE, reg_wdata = 16'h0000, reg_rdata, q, req [10], e [7];
   logic [31:0] v;
   mpm_job_t    job;
   mpm_result_t job_result, outcome = '0;
   int          mismatches = 0, num_checks = 0, cycles = 0, seed = 22525, n;
   always #50 core_clk = ~core_clk;
   mpm_mailbox dut (.CORE_CLK(core_clk), .RESETN(resetn), .CLK_EN(clk_en), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_HIT(reg_hit), .JOB_START(job_start),
      .JOB(job), .JOB_DONE(job_done), .JOB_RESULT(job_result));
   mpm_engine_model engine (.core_clk(core_clk), .start(job_start), .delay(delay), .outcome(outcome),
      .done(job_done), .result(job_result));
   task automatic wrap_up();
      if (mismatches == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         mismatches++;
         $display("ERROR %0t: got %h want %h", $time, got, want);
      end
   endtask : chk
   // Called at a falling edge; strobes stay up so back-to-back calls never drive a signal twice.
   task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic w);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = ~w;
      @(negedge core_clk);
   endtask : acc
   task automatic run_job(input logic [3:0] p, input logic [15:0] pv);
      for (int i = 1; i < 10; i++) acc(MBX_BASE + 16'(i), req[i], 1'b1);
      acc(MBX_BASE, CTRL_ACTIVE, 1'b1);
      chk(reg_hit, 1'b1);
      chk(job_start, go);
      acc(MBX_BASE + {12'h000, p}, 16'h0000, 1'b0);
      if (go) chk(reg_rdata, pv);
      acc(MBX_BASE + 16'h0003, 16'h5a5a, 1'b1);
      q = CTRL_ACTIVE;
      for (int i = 0; i < 40 && q == CTRL_ACTIVE; i++) begin
         acc(MBX_BASE, 16'h0000, 1'b0);
         q = reg_rdata;
      end
      chk(q, CTRL_DONE);
   endtask : run_job
   initial begin
      repeat (8) @(negedge core_clk);
      resetn = 1'b1;
      acc(16'h0100, 16'h1234, 1'b1);
      chk(reg_hit, 1'b0);
      acc(16'h0100, 16'h0000, 1'b0);
      acc(MBX_BASE, CTRL_FILLING, 1'b1);
      chk(reg_rdata, 16'h0000);
      acc(MBX_BASE, 16'h0000, 1'b0);
      chk(reg_rdata, CTRL_FILLING);
      // A write while the clock enable is low must leave the word untouched.
      clk_en = 1'b0;
      acc(MBX_BASE + 16'h0001, 16'hbeef, 1'b1);
      clk_en = 1'b1;
      acc(MBX_BASE + 16'h0001, 16'h0000, 1'b0);
      chk(reg_rdata, 16'h0000);
      for (int k = 0; k < 7; k++) begin
         ref_b = 8'($random(seed));
         v = $random(seed);
         f = 8'($unsigned($random(seed)) % 6);
         delay = (k == 1) ? 8'h00 : 8'($unsigned($random(seed)) % 8);
         go = (k < 4);
         req = '{16'h0000, 16'h2f0a, {ref_b, TYPE_READ}, 16'h0101, 16'h1001, 16'h0002, 16'h0000, 16'h0801,
                 v[31:16], v[15:0]};
         outcome = '{k != 3, f, 8'h03, k == 2, k == 2 ? v : {16'h0000, v[15:0]}};
         if (k == 1) req[1:2] = '{16'h2f10, {ref_b, TYPE_CHANGE}};
         if (k == 4) req[1] = 16'h300a;
         if (k == 5) req[1] = 16'h2f09;
         if (k == 6) req[2][7:0] = 8'h03;
         run_job(k == 0 ? 4'h0 : 4'h2, k == 0 ? CTRL_ACTIVE : {8'h00, FAULT_NOT_READY});
         e = '{CTRL_DONE, {FUNC_PARAM, k == 1 ? LEN_CHANGE_RESP : k == 2 ? 8'h0a : 8'h08}, {ref_b, req[2][7:0]},
               req[3], {8'h03, req[4][7:0]}, k == 2 ? v[31:16] : v[15:0], v[15:0]};
         n = (k == 1) ? 4 : (k == 2) ? 7 : 6;
         if (k > 2) e[1:2] = '{{FUNC_PARAM, LEN_ERROR}, {8'h00, k == 3 ? (f == 8'h00 ? FAULT_INTERNAL : f) :
               k == 4 ? FAULT_FUNCTION : k == 5 ? FAULT_LENGTH : FAULT_STATE}};
         if (k > 2) n = 3;
         for (int i = 0; i < n; i++) begin
            acc(MBX_BASE + 16'(i), 16'h0000, 1'b0);
            chk(reg_rdata, e[i]);
         end
         chk(job.param_number, req[5]);
         if (k == 1) chk(job.value, v);
      end
      wrap_up();
   end
endmodule : mpm_mailbox_bench
